// File: rtl/phu_prefetch_hint_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "phu_params.svh"

module phu_prefetch_hint_unit
    import phu_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire phu_req_t    req,
    output logic             req_ready,
    output phu_resp_t        resp,
    input  wire logic        cp0_enable,
    input  wire logic        order_ok,
    output phu_xreq_t        xreq,
    input  wire phu_xrsp_t   xrsp,
    output phu_creq_t        creq,
    input  wire phu_crsp_t   crsp
);

typedef struct packed {
    phu_fsm_t    fsm;
    logic        req_ready;
    phu_resp_t   resp;
    phu_xreq_t   xreq;
    phu_creq_t   creq;
    phu_var_t    variant;
    logic [4:0]  hint;
    logic [3:0]  ctrl;
    logic [15:0] issued;
    logic [15:0] dropped;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
} phu_st_t;

phu_st_t r;
phu_st_t next_r;

// hint classification: only architected actions are carried out
function automatic logic hint_known(input logic [4:0] h);
    case (h)
        `PHU_HINT_LOAD, `PHU_HINT_STORE,
        `PHU_HINT_LOAD_STR, `PHU_HINT_STORE_STR,
        `PHU_HINT_LOAD_RET, `PHU_HINT_STORE_RET,
        `PHU_HINT_WB_INV, `PHU_HINT_ZERO_FILL: hint_known = 1'b1;
        default: hint_known = 1'b0;
    endcase
endfunction

// ----------------------------------------------------------------
// next-state logic
// ----------------------------------------------------------------
logic [31:0] va;
logic [31:0] sext9;
logic [31:0] sext16;
logic        accept;
logic        ahb_go;
logic        user_seg;

always_comb
begin
    next_r = r;
    next_r.resp.valid = 1'b0;
    next_r.creq.valid = 1'b0;
    next_r.xreq.valid = 1'b0;
    // user variant offset is 9 bits, base variant 16; indexed adds index, no offset
    sext9  = {{23{req.offset[`PHU_OFS9_MSB]}}, req.offset[8:0]};
    sext16 = {{16{req.offset[15]}}, req.offset};
    case (req.variant)
        PHU_VAR_INDEXED: va = req.base + req.index;
        PHU_VAR_USER:    va = req.base + sext9;
        default:         va = req.base + sext16;
    endcase
    accept   = req.valid && r.req_ready;
    user_seg = xrsp.seg != PHU_SEG_KERNEL_ONLY;
    ahb_go   = hsel && hready && htrans == `PHU_HTRANS_NONSEQ;

    case (r.fsm)
        PHU_IDLE:
        begin
            if (accept)
            begin
                next_r.req_ready = 1'b0;
                next_r.variant   = req.variant;
                next_r.hint      = req.hint;
                next_r.fsm       = PHU_RESP;
                next_r.resp.exc  = `PHU_EXC_NONE;
                if (req.variant == PHU_VAR_USER && !r.ctrl[`PHU_CTRL_EVA])
                    next_r.resp.exc = `PHU_EXC_RI;
                else if (req.variant == PHU_VAR_USER && !cp0_enable)
                    next_r.resp.exc = `PHU_EXC_CPU;
                else if (req.variant == PHU_VAR_INDEXED
                         && !r.ctrl[`PHU_CTRL_FPU])
                    next_r.resp.exc = `PHU_EXC_RI;
                else if (!hint_known(req.hint))
                    next_r.dropped = r.dropped + 16'h0001;
                else
                begin
                    next_r.xreq.valid    = 1'b1;
                    next_r.xreq.va       = va;
                    next_r.xreq.user_map = req.variant == PHU_VAR_USER;
                    next_r.fsm           = PHU_XLATE;
                end
            end
        end
        PHU_XLATE:
        begin
            if (xrsp.valid)
            begin
                // faults, uncached and kernel-only user access all drop
                if (xrsp.fault || xrsp.uncached
                    || (r.variant == PHU_VAR_USER && !user_seg))
                begin
                    next_r.dropped = r.dropped + 16'h0001;
                    next_r.fsm     = PHU_RESP;
                end
                else
                begin
                    next_r.creq.pa = xrsp.pa;
                    next_r.creq.cacheability_attribute =
                        xrsp.cacheability_attribute;
                    next_r.creq.coherent = xrsp.coherent;
                    next_r.fsm = PHU_ISSUE;
                end
            end
        end
        PHU_ISSUE:
        begin
            // earlier memory traffic must drain first, as for a barrier
            if (order_ok)
            begin
                next_r.creq.valid     = 1'b1;
                next_r.creq.op        = PHU_OP_FETCH;
                next_r.creq.for_store = r.hint[0];
                next_r.creq.streamed  = r.hint == `PHU_HINT_LOAD_STR
                    || r.hint == `PHU_HINT_STORE_STR;
                next_r.creq.retained  = r.hint == `PHU_HINT_LOAD_RET
                    || r.hint == `PHU_HINT_STORE_RET;
                next_r.creq.clean_inv = 1'b0;
                next_r.creq.spare_locked = 1'b1;
                if (r.hint == `PHU_HINT_WB_INV)
                begin
                    next_r.creq.op        = PHU_OP_WB_INV;
                    next_r.creq.for_store = 1'b0;
                    next_r.creq.clean_inv =
                        r.ctrl[`PHU_CTRL_CLEANINV];
                end
                else if (r.hint == `PHU_HINT_ZERO_FILL)
                begin
                    next_r.creq.op        = PHU_OP_ZERO_FILL;
                    next_r.creq.for_store = 1'b1;
                end
                next_r.issued = r.issued + 16'h0001;
                next_r.fsm    = PHU_CACHE;
            end
        end
        PHU_CACHE:
        begin
            // completion is the cache's done, refills included
            if (crsp.done)
            begin
                if (crsp.err && r.ctrl[`PHU_CTRL_BUSERR])
                    next_r.resp.exc = `PHU_EXC_BUS;
                next_r.fsm = PHU_RESP;
            end
        end
        PHU_RESP:
        begin
            next_r.resp.valid = 1'b1;
            next_r.req_ready  = 1'b1;
            next_r.fsm        = PHU_IDLE;
        end
        default:
        begin
            next_r.fsm       = PHU_IDLE;
            next_r.req_ready = 1'b1;
        end
    endcase

    // bus slave: data-phase write, read data staged at address phase
    next_r.dph_wr   = ahb_go && hwrite;
    next_r.dph_addr = haddr[7:0];
    if (r.dph_wr && r.dph_addr == `PHU_OFF_CTRL)
        next_r.ctrl = hwdata[3:0];
    // software clear of counters loses to a same-cycle count
    if (r.dph_wr && r.dph_addr == `PHU_OFF_STAT)
    begin
        if (next_r.issued == r.issued)
            next_r.issued = 16'h0000;
        if (next_r.dropped == r.dropped)
            next_r.dropped = 16'h0000;
    end
    next_r.hrdata = 32'h0000_0000;
    if (ahb_go && !hwrite)
    begin
        case (haddr[7:0])
            `PHU_OFF_CTRL:    next_r.hrdata = {28'h0000000, r.ctrl};
            `PHU_OFF_STAT:    next_r.hrdata = {31'h00000000,
                                               r.fsm != PHU_IDLE};
            `PHU_OFF_ISSUED:  next_r.hrdata = {16'h0000, r.issued};
            `PHU_OFF_DROPPED: next_r.hrdata = {16'h0000, r.dropped};
            default:          next_r.hrdata = 32'h0000_0000;
        endcase
    end
    next_r.hreadyout = 1'b1;
    // no error path exists on this bus, so the answer is held OKAY
    next_r.hresp     = 1'b0;
end

// ----------------------------------------------------------------
// state register
// ----------------------------------------------------------------
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        r           <= '0;
        r.fsm       <= PHU_IDLE;
        r.req_ready <= 1'b1;
        r.ctrl      <= `PHU_CTRL_RST;
        r.hreadyout <= 1'b1;
    end
    else
        r <= next_r;
end

// outputs straight from the state flops
assign req_ready = r.req_ready;
assign resp      = r.resp;
assign xreq      = r.xreq;
assign creq      = r.creq;
assign hreadyout = r.hreadyout;
assign hrdata    = r.hrdata;
assign hresp     = r.hresp; // always OKAY

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);

chk_uncached_drop: assert property (
    r.fsm == PHU_XLATE && xrsp.valid && xrsp.uncached
    |=> r.fsm == PHU_RESP ##1 !creq.valid)
    else $error("uncached prefetch reached the cache");
chk_fault_silent: assert property (
    r.fsm == PHU_XLATE && xrsp.valid && xrsp.fault
    |=> ##1 resp.valid && resp.exc == `PHU_EXC_NONE)
    else $error("faulting prefetch raised an exception");
chk_attr_follow: assert property (
    r.fsm == PHU_XLATE && xrsp.valid && !xrsp.fault && !xrsp.uncached
    && (r.variant != PHU_VAR_USER || xrsp.seg != PHU_SEG_KERNEL_ONLY)
    |=> creq.cacheability_attribute == $past(xrsp.cacheability_attribute)
    && creq.coherent == $past(xrsp.coherent))
    else $error("cache request attribute not the translated one");
chk_order_wait: assert property (
    creq.valid |-> $past(order_ok))
    else $error("cache request issued before ordering cleared");
chk_user_no_eva: assert property (
    req.valid && req_ready && req.variant == PHU_VAR_USER
    && !r.ctrl[`PHU_CTRL_EVA]
    |=> ##1 resp.valid && resp.exc == `PHU_EXC_RI)
    else $error("user variant accepted without extended addressing");
chk_indexed_fpu: assert property (
    req.valid && req_ready && req.variant == PHU_VAR_INDEXED
    && !r.ctrl[`PHU_CTRL_FPU] |=> !xreq.valid ##1 resp.valid)
    else $error("indexed variant ran without floating point");
chk_reserved_nop: assert property (
    req.valid && req_ready && !hint_known(req.hint)
    && req.variant == PHU_VAR_BASE
    |=> !xreq.valid ##1 resp.valid && resp.exc == `PHU_EXC_NONE)
    else $error("reserved hint was not a silent no-op");
chk_zero_fill_op: assert property (
    creq.valid && r.hint == `PHU_HINT_ZERO_FILL
    |-> creq.op == PHU_OP_ZERO_FILL && creq.spare_locked)
    else $error("zero-fill hint issued wrong operation");
chk_resp_pulse: assert property (
    resp.valid |-> req_ready ##1 !resp.valid)
    else $error("answer held longer than one cycle");
chk_ready_idle: assert property (
    req_ready |-> r.fsm == PHU_IDLE)
    else $error("request taken while a prefetch is in flight");
chk_issue_hold: assert property (
    r.fsm == PHU_ISSUE && !order_ok |=> r.fsm == PHU_ISSUE && !creq.valid)
    else $error("cache request left before ordering cleared");

// ----------------------------------------------------------------
// address formation and access checks
// ----------------------------------------------------------------
// the expected address is rebuilt from the request as it was taken,
// so a wrong offset width or a wrong operand shows up here
chk_va_base: assert property (
    xreq.valid && r.variant == PHU_VAR_BASE
    |-> xreq.va == $past(req.base + {{16{req.offset[15]}}, req.offset}))
    else $error("base-offset address formed wrongly");
chk_va_user: assert property (
    xreq.valid && r.variant == PHU_VAR_USER
    |-> xreq.va == $past(req.base + {{23{req.offset[8]}}, req.offset[8:0]}))
    else $error("user variant offset not 9-bit signed");
chk_va_indexed: assert property (
    xreq.valid && r.variant == PHU_VAR_INDEXED
    |-> xreq.va == $past(req.base + req.index))
    else $error("indexed address formed wrongly");
chk_user_map: assert property (
    xreq.valid |-> xreq.user_map == (r.variant == PHU_VAR_USER))
    else $error("user mapping flag does not follow the variant");
chk_user_cp0: assert property (
    req.valid && req_ready && req.variant == PHU_VAR_USER
    && r.ctrl[`PHU_CTRL_EVA] && !cp0_enable
    |=> !xreq.valid ##1 resp.valid && resp.exc == `PHU_EXC_CPU)
    else $error("user variant ran without coprocessor access");
chk_user_seg: assert property (
    r.fsm == PHU_XLATE && xrsp.valid && r.variant == PHU_VAR_USER
    && xrsp.seg == PHU_SEG_KERNEL_ONLY
    |=> r.fsm == PHU_RESP ##1 resp.valid && resp.exc == `PHU_EXC_NONE)
    else $error("user variant reached a kernel-only segment");

// ----------------------------------------------------------------
// cache request checks
// ----------------------------------------------------------------
// the physical address must be the translated one, never a stale copy
chk_block_addr: assert property (
    r.fsm == PHU_XLATE && xrsp.valid && !xrsp.fault && !xrsp.uncached
    && (r.variant != PHU_VAR_USER || xrsp.seg != PHU_SEG_KERNEL_ONLY)
    |=> creq.pa == $past(xrsp.pa))
    else $error("cache request address not the translated one");
chk_fetch_dir: assert property (
    creq.valid && (r.hint == `PHU_HINT_LOAD || r.hint == `PHU_HINT_STORE)
    |-> creq.op == PHU_OP_FETCH && !creq.streamed && !creq.retained
    && creq.for_store == (r.hint == `PHU_HINT_STORE))
    else $error("load or store hint fetched the wrong way");
chk_streamed_hint: assert property (
    creq.valid && (r.hint == `PHU_HINT_LOAD_STR || r.hint == `PHU_HINT_STORE_STR)
    |-> creq.op == PHU_OP_FETCH && creq.streamed && !creq.retained
    && creq.for_store == (r.hint == `PHU_HINT_STORE_STR))
    else $error("streamed hint not placed as streamed");
chk_retained_hint: assert property (
    creq.valid && (r.hint == `PHU_HINT_LOAD_RET || r.hint == `PHU_HINT_STORE_RET)
    |-> creq.op == PHU_OP_FETCH && creq.retained && !creq.streamed
    && creq.for_store == (r.hint == `PHU_HINT_STORE_RET))
    else $error("retained hint not placed as retained");
// the clean-line choice is the one software set when the request left
chk_wb_inv_op: assert property (
    creq.valid && r.hint == `PHU_HINT_WB_INV
    |-> creq.op == PHU_OP_WB_INV && !creq.for_store
    && creq.clean_inv == $past(r.ctrl[`PHU_CTRL_CLEANINV]))
    else $error("writeback-invalidate hint issued wrong operation");
chk_locked_spared: assert property (
    creq.valid |-> creq.spare_locked)
    else $error("cache request may touch locked lines");
// error reporting follows the software switch in both directions
chk_err_quiet: assert property (
    r.fsm == PHU_CACHE && crsp.done && crsp.err && !r.ctrl[`PHU_CTRL_BUSERR]
    |=> ##1 resp.valid && resp.exc == `PHU_EXC_NONE)
    else $error("masked cache error was reported");
chk_err_report: assert property (
    r.fsm == PHU_CACHE && crsp.done && crsp.err && r.ctrl[`PHU_CTRL_BUSERR]
    |=> ##1 resp.valid && resp.exc == `PHU_EXC_BUS)
    else $error("enabled cache error was not reported");

cov_fetch_done: cover property (creq.valid ##[1:50] resp.valid);
cov_wb_inv: cover property (creq.valid && creq.op == PHU_OP_WB_INV);
cov_fault: cover property (r.fsm == PHU_XLATE && xrsp.valid && xrsp.fault);
cov_user_ok: cover property (xreq.valid && xreq.user_map);
cov_bus_err: cover property (resp.valid && resp.exc == `PHU_EXC_BUS);

endmodule
`default_nettype wire

// File: rtl/phu_params.svh
`ifndef PHU_PARAMS_SVH
`define PHU_PARAMS_SVH

// hint encodings
`define PHU_HINT_LOAD       5'h00
`define PHU_HINT_STORE      5'h01
`define PHU_HINT_LOAD_STR   5'h04
`define PHU_HINT_STORE_STR  5'h05
`define PHU_HINT_LOAD_RET   5'h06
`define PHU_HINT_STORE_RET  5'h07
`define PHU_HINT_WB_INV     5'h19
`define PHU_HINT_ZERO_FILL  5'h1E

// register byte offsets
`define PHU_OFF_CTRL        8'h00
`define PHU_OFF_STAT        8'h04
`define PHU_OFF_ISSUED      8'h08
`define PHU_OFF_DROPPED     8'h0C

// control bit positions and reset value
`define PHU_CTRL_EVA        0
`define PHU_CTRL_FPU        1
`define PHU_CTRL_BUSERR     2
`define PHU_CTRL_CLEANINV   3
`define PHU_CTRL_RST        4'h3

// exception codes
`define PHU_EXC_NONE        2'h0
`define PHU_EXC_RI          2'h1
`define PHU_EXC_CPU         2'h2
`define PHU_EXC_BUS         2'h3

`define PHU_OFS9_MSB        8
`define PHU_HTRANS_NONSEQ   2'h2

`endif

// File: rtl/phu_pkg.sv
package phu_pkg;

typedef enum logic [1:0] {
    PHU_VAR_BASE,
    PHU_VAR_USER,
    PHU_VAR_INDEXED
} phu_var_t;

typedef enum logic [1:0] {
    PHU_SEG_KERNEL_ONLY,
    PHU_SEG_MAPPED_USER_UNMAPPED_KERNEL,
    PHU_SEG_UNMAPPED_USER_SUPER_KERNEL,
    PHU_SEG_MAPPED_USER_SUPER_KERNEL
} phu_seg_t;

typedef enum logic [1:0] {
    PHU_OP_FETCH,
    PHU_OP_WB_INV,
    PHU_OP_ZERO_FILL
} phu_op_t;

typedef enum {
    PHU_IDLE,
    PHU_XLATE,
    PHU_ISSUE,
    PHU_CACHE,
    PHU_RESP
} phu_fsm_t;

typedef struct packed {
    logic        valid;
    phu_var_t    variant;
    logic [4:0]  hint;
    logic [31:0] base;
    logic [15:0] offset;
    logic [31:0] index;
} phu_req_t;

typedef struct packed {
    logic        valid;
    logic [31:0] va;
    logic        user_map;
} phu_xreq_t;

typedef struct packed {
    logic        valid;
    logic [31:0] pa;
    logic [2:0]  cacheability_attribute;
    logic        uncached;
    logic        coherent;
    logic        fault;
    phu_seg_t    seg;
} phu_xrsp_t;

typedef struct packed {
    logic        valid;
    phu_op_t     op;
    logic [31:0] pa;
    logic [2:0]  cacheability_attribute;
    logic        for_store;
    logic        streamed;
    logic        retained;
    logic        coherent;
    logic        clean_inv;
    logic        spare_locked;
} phu_creq_t;

typedef struct packed {
    logic done;
    logic err;
} phu_crsp_t;

typedef struct packed {
    logic       valid;
    logic [1:0] exc;
} phu_resp_t;

endpackage

// File: bench/phu_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// translation buffer and cache stand-in
// ----------------------------------------
module phu_far_model
    import phu_pkg::*;
(
    input  wire logic      hclk,
    input  wire logic      hresetn,
    input  wire phu_xrsp_t xcfg,
    input  wire logic      slow,
    input  wire logic      cerr,
    input  wire phu_xreq_t xreq,
    output phu_xrsp_t      xrsp,
    input  wire phu_creq_t creq,
    output phu_crsp_t      crsp
);
    logic [2:0]  xcnt;
    logic [2:0]  ccnt;
    logic [31:0] va_q;

    // identity mapping; pa is scrambled outside the answer cycle so a
    // design that samples it late sees garbage, not a lucky stale value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xcnt <= 3'h0;
            ccnt <= 3'h0;
            va_q <= 32'h0;
            xrsp <= '0;
            crsp <= '0;
        end
        else
        begin
            xcnt <= xreq.valid ? (slow ? 3'h4 : 3'h1) : (xcnt == 3'h0 ? 3'h0 : xcnt - 3'h1);
            ccnt <= creq.valid ? (slow ? 3'h4 : 3'h1) : (ccnt == 3'h0 ? 3'h0 : ccnt - 3'h1);
            if (xreq.valid)
                va_q <= xreq.va;
            xrsp <= xcfg;
            xrsp.valid <= (xcnt == 3'h1);
            xrsp.pa <= (xcnt == 3'h1) ? va_q : ~va_q;
            crsp.done <= (ccnt == 3'h1);
            crsp.err <= (ccnt == 3'h1) & cerr;
        end
    end
endmodule

`default_nettype wire

// File: bench/phu_prefetch_hint_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "phu_params.svh"

module phu_prefetch_hint_unit_tb
    import phu_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hready, req_ready, hresp;
    logic        cp0_enable, order_ok, slow, cerr, ord_q;
    logic [1:0]  htrans, e;
    logic [2:0]  hsize;
    logic [3:0]  ctrl;
    logic [31:0] haddr, hwdata, hrdata, seed, v;
    logic [31:0] bg = 32'h0ADE;
    phu_req_t    req;
    phu_resp_t   resp;
    phu_xreq_t   xreq, xq;
    phu_xrsp_t   xrsp, xcfg;
    phu_creq_t   creq, cq;
    phu_crsp_t   crsp;
    int          error_cnt, samples_checked, n_c;

    phu_prefetch_hint_unit DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .req(req), .req_ready(req_ready), .resp(resp), .cp0_enable(cp0_enable),
        .order_ok(order_ok), .xreq(xreq), .xrsp(xrsp), .creq(creq), .crsp(crsp));

    phu_far_model far (
        .hclk(hclk), .hresetn(hresetn), .xcfg(xcfg), .slow(slow), .cerr(cerr),
        .xreq(xreq), .xrsp(xrsp), .creq(creq), .crsp(crsp));

    // ----------------------------------------
    // clock, background noise, monitor
    // ----------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // barrier drain and far-side speed wander so issue waits get exercised
    always @(posedge hclk)
    begin
        bg <= lfsr(bg);
        order_ok <= bg[0] | bg[1];
        slow <= bg[2];
    end

    always @(posedge hclk)
    begin
        if (xreq.valid === 1'b1)
            xq = xreq;
        if (creq.valid === 1'b1)
        begin
            cq = creq;
            n_c++;
            check(32'(ord_q), 32'h1);
        end
        ord_q = order_ok;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] rnd();
        seed = lfsr(seed);
        return seed;
    endfunction

    function automatic logic [31:0] va_of(input phu_var_t t, input logic [31:0] b,
                                          input logic [15:0] o, input logic [31:0] ix);
        if (t == PHU_VAR_USER)
            return b + {{23{o[8]}}, o[8:0]};
        if (t == PHU_VAR_INDEXED)
            return b + ix;
        return b + {{16{o[15]}}, o};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hung handshake counts as a mismatch and ends the run
    task automatic to_chk(inout int n);
        n++;
        if (n > 300)
        begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= `PHU_HTRANS_NONSEQ;
        do begin @(posedge hclk); to_chk(n); end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); to_chk(n); end while (hready !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask

    task automatic set_ctrl(input logic [3:0] c);
        ctrl = c;
        ahb(1'b1, `PHU_OFF_CTRL, {28'h0, c}, v);
        ahb(1'b0, `PHU_OFF_CTRL, 32'h0, v);
        check(v, {28'h0, c});
    endtask

    task automatic pf(input phu_var_t t, input logic [4:0] h, input logic [31:0] b,
                      input logic [15:0] o, input logic [31:0] ix);
        int n;
        n = 0;
        n_c = 0;
        @(posedge hclk);
        req <= '{1'b1, t, h, b, o, ix};
        do begin @(posedge hclk); to_chk(n); end while (req_ready !== 1'b1);
        req.valid <= 1'b0;
        do begin @(posedge hclk); to_chk(n); end while (resp.valid !== 1'b1);
        e = resp.exc;
    endtask

    task automatic hint_case(input phu_var_t t, input logic [4:0] h);
        logic [31:0] b, ix;
        logic [15:0] o;
        logic        f, iss;
        phu_op_t     op;
        b = rnd();
        ix = rnd();
        o = 16'(rnd());
        f = h inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07};
        iss = f || h == `PHU_HINT_WB_INV || h == `PHU_HINT_ZERO_FILL;
        op = h == `PHU_HINT_WB_INV ? PHU_OP_WB_INV :
             h == `PHU_HINT_ZERO_FILL ? PHU_OP_ZERO_FILL : PHU_OP_FETCH;
        pf(t, h, b, o, ix);
        check(32'(e), 32'h0);
        check(32'(n_c), 32'(iss));
        if (iss)
        begin
            check(xq.va, va_of(t, b, o, ix));
            check(32'(xq.user_map), 32'(t == PHU_VAR_USER));
            check(32'(cq.op), 32'(op));
            check(cq.pa, xq.va);
            check(32'({cq.cacheability_attribute, cq.coherent, cq.spare_locked}),
                  32'({xcfg.cacheability_attribute, xcfg.coherent, 1'b1}));
            if (f)
                check(32'({cq.for_store, cq.streamed, cq.retained}),
                      32'({h[0], h[2:1] == 2'h2, h[2:1] == 2'h3}));
            if (h == `PHU_HINT_WB_INV)
                check(32'(cq.clean_inv), 32'(ctrl[3]));
        end
    endtask

    task automatic exc_case(input logic [3:0] c, input logic cp, input phu_var_t t,
                            input logic [1:0] x);
        set_ctrl(c);
        cp0_enable <= cp;
        pf(t, 5'h00, rnd(), 16'h0, 32'h0);
        check(32'(x == 2'h0 ? e != 2'h0 : e == x), 32'h1);
        check(32'(n_c), 32'h0);
        cp0_enable <= 1'b1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, cp0_enable, cerr} = 5'b00010;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        req = '0;
        xcfg = '0;
        seed = 32'h0ADE;
        ctrl = 4'h3;
        error_cnt = 0;
        samples_checked = 0;
        n_c = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `PHU_OFF_CTRL, 32'h0, v);
        check(v, 32'h3);
        ahb(1'b1, `PHU_OFF_ISSUED, 32'hFFFF, v);
        ahb(1'b0, `PHU_OFF_ISSUED, 32'h0, v);
        check(v, 32'h0);
        ahb(1'b0, 8'h10, 32'h0, v);
        check(v, 32'h0);
        $display("test registers done");
        // every hint code, then user and indexed forms with clean invalidation on
        for (int k = 0; k < 64; k++)
        begin
            if (k == 32)
                set_ctrl(4'hB);
            xcfg.cacheability_attribute = 3'(rnd());
            xcfg.coherent = seed[5];
            xcfg.seg = phu_seg_t'(seed[9:8] == 2'h0 ? 2'h1 : seed[9:8]);
            hint_case(phu_var_t'(k < 32 ? 2'h0 : {k[0], ~k[0]}), 5'(k));
        end
        $display("test hints done");
        // uncached, faulting and kernel-only user accesses vanish quietly
        for (int k = 0; k < 3; k++)
        begin
            xcfg.uncached = (k == 0);
            xcfg.fault = (k == 1);
            xcfg.seg = k == 2 ? PHU_SEG_KERNEL_ONLY : PHU_SEG_MAPPED_USER_SUPER_KERNEL;
            pf(k == 2 ? PHU_VAR_USER : PHU_VAR_BASE, k == 1 ? 5'h1E : 5'h19, rnd(), 16'h0, 32'h0);
            check(32'({e, n_c[3:0]}), 32'h0);
        end
        xcfg.fault = 1'b0;
        $display("test drops done");
        exc_case(4'h2, 1'b1, PHU_VAR_USER, 2'h1);
        exc_case(4'h3, 1'b0, PHU_VAR_USER, 2'h2);
        exc_case(4'h1, 1'b1, PHU_VAR_INDEXED, 2'h0);
        cerr = 1'b1;
        set_ctrl(4'h7);
        pf(PHU_VAR_BASE, 5'h00, rnd(), 16'h0, 32'h0);
        check(32'(e), 32'h3);
        set_ctrl(4'h3);
        pf(PHU_VAR_BASE, 5'h00, rnd(), 16'h0, 32'h0);
        check(32'(e), 32'h0);
        cerr = 1'b0;
        $display("test exceptions done");
        ahb(1'b1, `PHU_OFF_STAT, 32'h0, v);
        pf(PHU_VAR_BASE, 5'h06, rnd(), 16'h0, 32'h0);
        pf(PHU_VAR_BASE, 5'h03, rnd(), 16'h0, 32'h0);
        ahb(1'b0, `PHU_OFF_ISSUED, 32'h0, v);
        check(v, 32'h1);
        ahb(1'b0, `PHU_OFF_DROPPED, 32'h0, v);
        check(v, 32'h1);
        $display("test counters done");
        complete_run();
    end
endmodule

`default_nettype wire
